// >>> hw/osrg_defines.vh
// Constants for the operation status register group
`ifndef OSRG_DEFINES_VH
`define OSRG_DEFINES_VH
`define OSRG_WIDTH      16
`define OSRG_BIT_ERR    13
`define OSRG_BIT_CLOSED 11
`define OSRG_BIT_REMOTE 10
`define OSRG_BIT_TRGW   5
`define OSRG_BIT_SCAN   4
`define OSRG_USED_MASK  16'h2c30
`define OSRG_ZERO       16'h0000
`define OSRG_SEL_COND   2'h0
`define OSRG_SEL_EVENT  2'h1
`define OSRG_SEL_ENABLE 2'h2
`define OSRG_SEL_SPARE  2'h3
`define OSRG_MASK_RESET 16'h0000
`define OSRG_EVT_RESET  16'h0000
`define OSRG_FLAG_IDLE  1'b0
`endif

// >>> hw/osrg_top.v
// Operation status register group: condition, event latch, enable mask
`timescale 1ns/100ps
`include "osrg_defines.vh"

// Contract
// - Condition query returns live 16-bit indicator word
// - Unassigned bit positions always read zero
// - Remote indicator has weight 1024
// - Enable write stores supplied mask value with unassigned bits cleared
// - Enable mask is zero after reset
// - Enable query forces unassigned bits zero
module osrg_top #(
    parameter WIDTH = `OSRG_WIDTH
) (
    // Clock and reset
    input  wire             REF_CLK,
    input  wire             RSTN,
    // Device indicators
    input  wire             ERROR_IND,
    input  wire             CLOSED_IND,
    input  wire             REMOTE_IND,
    input  wire             AWAITING_TRIGGER_IND,
    input  wire             SCANNING_IND,
    // Command port
    input  wire             QUERY_REQ,
    input  wire [1:0]       QUERY_SEL,
    input  wire             ENABLE_WR,
    input  wire [WIDTH-1:0] ENABLE_DATA,
    input  wire             STATUS_CLEAR,
    // Answer
    output reg  [WIDTH-1:0] QUERY_DATA,
    output reg              QUERY_VALID,
    output wire             SUMMARY
);

    // Select codes and masks at the module's width
    localparam [1:0]       SEL_COND    = `OSRG_SEL_COND;
    localparam [1:0]       SEL_EVENT   = `OSRG_SEL_EVENT;
    localparam [1:0]       SEL_ENABLE  = `OSRG_SEL_ENABLE;
    localparam [1:0]       SEL_SPARE   = `OSRG_SEL_SPARE;
    localparam [WIDTH-1:0] USED_BITS   = `OSRG_USED_MASK;
    localparam [WIDTH-1:0] ALL_ZERO    = `OSRG_ZERO;
    localparam [WIDTH-1:0] MASK_RESET  = `OSRG_MASK_RESET;
    localparam [WIDTH-1:0] EVT_RESET   = `OSRG_EVT_RESET;
    localparam             FLAG_IDLE   = `OSRG_FLAG_IDLE;

    // Stored state
    reg  [WIDTH-1:0] enable_mask;
    reg  [WIDTH-1:0] event_latch;
    reg              summary;

    // Next values
    reg  [WIDTH-1:0] next_enable_mask;
    reg  [WIDTH-1:0] next_event_latch;
    reg  [WIDTH-1:0] next_query_data;
    reg              next_query_valid;
    reg              next_summary;

    // Indicators under their own names
    wire             error_state      = ERROR_IND;
    wire             closed_state     = CLOSED_IND;
    wire             remote_state     = REMOTE_IND;
    wire             awaiting_trigger = AWAITING_TRIGGER_IND;
    wire             scanning_state   = SCANNING_IND;
    wire [WIDTH-1:0] condition;

    // Indicator placement
    function [WIDTH-1:0] place;
        input e;
        input c;
        input r;
        input t;
        input s;
        begin
            place = ALL_ZERO;
            place[`OSRG_BIT_ERR]    = e;
            place[`OSRG_BIT_CLOSED] = c;
            place[`OSRG_BIT_REMOTE] = r;
            place[`OSRG_BIT_TRGW]   = t;
            place[`OSRG_BIT_SCAN]   = s;
        end
    endfunction

    // Unassigned positions never leave the block
    function [WIDTH-1:0] clean_bits;
        input [WIDTH-1:0] raw;
        begin
            clean_bits = raw & USED_BITS;
        end
    endfunction

    // Select decode
    function sel_is;
        input [1:0] sel;
        input [1:0] code;
        begin
            sel_is = (sel == code);
        end
    endfunction

    // Any enabled event pending
    function any_enabled;
        input [WIDTH-1:0] events;
        input [WIDTH-1:0] mask;
        begin
            any_enabled = |(events & mask);
        end
    endfunction

    // Next latch content; set beats clear in one cycle
    function [WIDTH-1:0] latch_events;
        input [WIDTH-1:0] prev;
        input [WIDTH-1:0] cond;
        input             clear;
        begin
            if (clear) begin
                latch_events = cond;
            end else begin
                latch_events = prev | cond;
            end
        end
    endfunction

    // Answer word for one register select
    function [WIDTH-1:0] answer_word;
        input [1:0]       sel;
        input [WIDTH-1:0] cond;
        input [WIDTH-1:0] events;
        input [WIDTH-1:0] mask;
        begin
            if (sel_is(sel, SEL_COND)) begin
                answer_word = cond;
            end else if (sel_is(sel, SEL_EVENT)) begin
                answer_word = clean_bits(events);
            end else if (sel_is(sel, SEL_ENABLE)) begin
                answer_word = clean_bits(mask);
            end else if (sel_is(sel, SEL_SPARE)) begin
                answer_word = ALL_ZERO;
            end else begin
                answer_word = ALL_ZERO;
            end
        end
    endfunction

    // Live word: no memory, follows the pins
    assign condition = clean_bits(place(error_state, closed_state,
                                        remote_state, awaiting_trigger,
                                        scanning_state));

    // Event latch next value
    always @* begin
        next_event_latch = latch_events(event_latch, condition,
                                        STATUS_CLEAR);
    end

    // Enable mask keeps only assigned positions
    always @* begin
        if (ENABLE_WR) begin
            next_enable_mask = clean_bits(ENABLE_DATA);
        end else begin
            next_enable_mask = enable_mask;
        end
    end

    // Answer word for the selected register
    always @* begin
        next_query_data = answer_word(QUERY_SEL, condition, event_latch,
                                      enable_mask);
    end

    // One answer strobe per query
    always @* begin
        next_query_valid = QUERY_REQ;
    end

    // Summary tracks the registered latch and mask
    always @* begin
        next_summary = any_enabled(next_event_latch, next_enable_mask);
    end

    // Latched events
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            event_latch <= EVT_RESET;
        end else begin
            event_latch <= next_event_latch;
        end
    end

    // Enable mask
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            enable_mask <= MASK_RESET;
        end else begin
            enable_mask <= next_enable_mask;
        end
    end

    // Summary flop
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            summary <= FLAG_IDLE;
        end else begin
            summary <= next_summary;
        end
    end

    // Answer data holds until the next query
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            QUERY_DATA <= ALL_ZERO;
        end else if (QUERY_REQ) begin
            QUERY_DATA <= next_query_data;
        end
    end

    // Answer strobe
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            QUERY_VALID <= FLAG_IDLE;
        end else begin
            QUERY_VALID <= next_query_valid;
        end
    end

    // Masked summary of latched events
    assign SUMMARY = summary;

endmodule // osrg_top

// >>> tb/osrg_host.sv
// Host model issuing status commands
`timescale 1ns/100ps
module osrg_host (
    // Clock
    input  wire        clk,
    // Command strobes
    output reg         req,
    output reg         wr,
    output reg         clr,
    // Command fields
    output reg  [1:0]  sel,
    output reg  [15:0] wd
);
    initial {req, wr, clr, sel, wd} = 0;
    // Command held over one rising edge
    task cmd(input [1:0] s, input w, c, input [15:0] d);
        @(negedge clk) {sel, wr, clr, wd, req} = {s, w, c, d, ~(w | c)};
        @(negedge clk) {req, wr, clr} = 0;
    endtask
endmodule // osrg_host

// >>> tb/osrg_asserts.sv
// Checker for the status register group
`timescale 1ns/100ps
module osrg_chk (
    // Clock and reset
    input wire        REF_CLK,
    input wire        RSTN,
    // Indicators
    input wire        ERROR_IND,
    input wire        CLOSED_IND,
    input wire        REMOTE_IND,
    input wire        AWAITING_TRIGGER_IND,
    input wire        SCANNING_IND,
    // Commands
    input wire        QUERY_REQ,
    input wire [1:0]  QUERY_SEL,
    input wire        ENABLE_WR,
    input wire [15:0] ENABLE_DATA,
    input wire        STATUS_CLEAR,
    // Answer
    input wire [15:0] QUERY_DATA,
    input wire        QUERY_VALID
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    sequence s_wq;
        ENABLE_WR ##1 !ENABLE_WR ##1 QUERY_REQ && QUERY_SEL == 2'h2;
    endsequence
    sequence s_ev;
        REMOTE_IND ##1 QUERY_REQ && QUERY_SEL == 2'h1;
    endsequence
    sequence s_sc;
        STATUS_CLEAR && REMOTE_IND ##1 !STATUS_CLEAR
            ##1 QUERY_REQ && QUERY_SEL == 2'h1;
    endsequence
    property p_v; QUERY_REQ |=> QUERY_VALID; endproperty
    a_v: assert property (p_v) else $error("no answer");
    property p_z; QUERY_VALID |-> !(QUERY_DATA & ~16'h2c30); endproperty
    a_z: assert property (p_z) else $error("spare bit set");
    property p_r; QUERY_REQ && QUERY_SEL == 2'h0
        |=> QUERY_DATA[10] == $past(REMOTE_IND); endproperty
    a_r: assert property (p_r) else $error("remote weight");
    property p_s; QUERY_REQ && QUERY_SEL == 2'h3 |=> !QUERY_DATA; endproperty
    a_s: assert property (p_s) else $error("spare select");
    property p_w; s_wq |=> QUERY_DATA == ($past(ENABLE_DATA, 3) & 16'h2c30);
    endproperty
    a_w: assert property (p_w) else $error("mask store");
    property p_e; s_ev |=> QUERY_DATA[10]; endproperty
    a_e: assert property (p_e) else $error("event not latched");
    property p_c;
        QUERY_REQ && QUERY_SEL == 2'h0 |=> QUERY_DATA ==
            {2'h0, $past(ERROR_IND), 1'h0, $past(CLOSED_IND),
             $past(REMOTE_IND), 4'h0, $past(AWAITING_TRIGGER_IND),
             $past(SCANNING_IND), 4'h0};
    endproperty
    a_c: assert property (p_c) else $error("condition word");
    property p_h; !QUERY_REQ |=> $stable(QUERY_DATA); endproperty
    a_h: assert property (p_h) else $error("answer not held");
    property p_n; !QUERY_REQ |=> !QUERY_VALID; endproperty
    a_n: assert property (p_n) else $error("stray strobe");
    property p_k; s_sc |=> QUERY_DATA[10]; endproperty
    a_k: assert property (p_k) else $error("clear beat set");
endmodule // osrg_chk
bind osrg_top osrg_chk i_chk (
    .REF_CLK              (REF_CLK),
    .RSTN                 (RSTN),
    .ERROR_IND            (ERROR_IND),
    .CLOSED_IND           (CLOSED_IND),
    .REMOTE_IND           (REMOTE_IND),
    .AWAITING_TRIGGER_IND (AWAITING_TRIGGER_IND),
    .SCANNING_IND         (SCANNING_IND),
    .QUERY_REQ            (QUERY_REQ),
    .QUERY_SEL            (QUERY_SEL),
    .ENABLE_WR            (ENABLE_WR),
    .ENABLE_DATA          (ENABLE_DATA),
    .STATUS_CLEAR         (STATUS_CLEAR),
    .QUERY_DATA           (QUERY_DATA),
    .QUERY_VALID          (QUERY_VALID)
);

// >>> tb/osrg_top_bench.sv
// Bench for the status register group
`timescale 1ns/100ps
module osrg_top_bench;
    reg clk = 0, rstn = 0;
    reg [4:0] ind = 0;
    wire rq, wr, cl, v, sm;
    wire [1:0] s;
    wire [15:0] d, qd;
    integer error_cnt = 0, cmp_count = 0;
    always #25 clk = ~clk;
    osrg_host i_host(.clk(clk), .req(rq), .wr(wr), .clr(cl), .sel(s), .wd(d));
    osrg_top i_dut(.REF_CLK(clk), .RSTN(rstn), .ERROR_IND(ind[4]),
        .CLOSED_IND(ind[3]), .REMOTE_IND(ind[2]), .SCANNING_IND(ind[0]),
        .AWAITING_TRIGGER_IND(ind[1]), .QUERY_REQ(rq), .QUERY_SEL(s),
        .ENABLE_WR(wr), .ENABLE_DATA(d), .STATUS_CLEAR(cl),
        .QUERY_DATA(qd), .QUERY_VALID(v), .SUMMARY(sm));
    task q(input [1:0] e, input [15:0] x);
        i_host.cmd(e, 0, 0, 0);
        cmp_count++;
        if (v !== 1 || qd !== x) begin
            error_cnt++;
            $display("MISMATCH query %0d exp %h seen %h", e, x, qd);
        end
        $display("query %0d done", e);
    endtask
    task chk(input [63:0] what, input [15:0] x, input [15:0] seen);
        cmp_count++;
        if (seen !== x) begin
            error_cnt++;
            $display("MISMATCH %0s exp %h seen %h", what, x, seen);
        end
        $display("%0s check done", what);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #20000 error_cnt++;
        wrap_up;
    end
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1;
        q(2, 0);
        ind = 5'h04;
        q(0, 16'h0400);
        ind = 5'h1f;
        q(0, 16'h2c30);
        q(1, 16'h2c30);
        ind = 0;
        q(1, 16'h2c30);
        i_host.cmd(0, 0, 1, 0);
        q(1, 0);
        i_host.cmd(0, 1, 0, 16'hffff);
        q(2, 16'h2c30);
        @(negedge clk);
        chk("held", 16'h2c30, qd);
        chk("strobe", 16'h0000, {15'h0000, v});
        chk("summary", 16'h0000, {15'h0000, sm});
        q(3, 0);
        ind = 5'h04;
        q(1, 16'h0400);
        chk("summary", 16'h0001, {15'h0000, sm});
        i_host.cmd(0, 0, 1, 0);
        q(1, 16'h0400);
        ind = 0;
        i_host.cmd(0, 0, 1, 0);
        q(1, 16'h0000);
        chk("summary", 16'h0000, {15'h0000, sm});
        ind = 5'h04;
        @(negedge clk);
        chk("summary", 16'h0001, {15'h0000, sm});
        rstn = 0;
        repeat (2) @(negedge clk);
        rstn = 1;
        q(2, 16'h0000);
        chk("summary", 16'h0000, {15'h0000, sm});
        q(1, 16'h0400);
        wrap_up;
    end
endmodule // osrg_top_bench
